// ===== hdl/crc_ctrl.sv
// card reader controller with host transfer engine behind an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
module crc_ctrl
  import crc_pkg::*;
#(
  parameter int COL_CYCLES = crc_pkg::COL_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] card_column,
  output logic irq_data,
  output logic irq_eop,
  output logic irq_alarm
);
  import crc_pkg::*;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RUN = 1'b1
  } crc_rd_e;

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_go;
  logic wr_hit;

  assign s_axi_awready = ~aw_have_ff;
  assign s_axi_wready = ~w_have_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wr_hit = (awaddr_ff == REG_CMD) | (awaddr_ff == REG_MASK);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      aw_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid & ~aw_have_ff)
    begin
      aw_have_ff <= 1'b1;
      awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
    end
    else if (wr_go)
      aw_have_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      w_have_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid & ~w_have_ff)
    begin
      w_have_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (wr_go)
      w_have_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= AXI_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // host transfer decode
  // ----------------------------------------------------------------
  logic exec;
  logic [1:0] station;
  crc_op_e op;
  logic [15:0] fw;
  logic fn_station;
  logic func_ok;
  logic f_clr_ctl;
  logic f_clr_int;
  logic f_feed;
  logic data_in_ok;
  logic [2:0] sel_req;

  assign exec = wr_go & (awaddr_ff == REG_CMD);
  assign station = wdata_ff[CMD_STATION_LSB +: 2];
  assign op = crc_op_e'(wdata_ff[CMD_OP_LSB +: 2]);
  assign fw = wdata_ff[CMD_FUNC_LSB +: 16];
  // only the reader and aux stations take functions
  assign fn_station = (station == ST_READER) | (station == ST_AUX);
  assign func_ok = exec & (op == OP_FUNC) & fn_station;
  assign f_clr_ctl = func_ok & fw[FB_CLR_CTL];
  assign f_clr_int = func_ok & fw[FB_CLR_INT];
  assign f_feed = func_ok & fw[FB_FEED];
  assign sel_req[IX_DATA] = func_ok & fw[FB_DATA_INT];
  assign sel_req[IX_EOP] = func_ok & fw[FB_EOP_INT];
  assign sel_req[IX_ALARM] = func_ok & fw[FB_ALARM_INT];

  // ----------------------------------------------------------------
  // column input synchroniser
  // ----------------------------------------------------------------
  logic [11:0] col_s1_ff;
  logic [11:0] col_s2_ff;
  logic [11:0] col_s3_ff;
  logic [11:0] col_stable_ff;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      col_s1_ff <= 12'h000;
      col_s2_ff <= 12'h000;
      col_s3_ff <= 12'h000;
      col_stable_ff <= 12'h000;
    end
    else
    begin
      col_s1_ff <= card_column;
      col_s2_ff <= col_s1_ff;
      col_s3_ff <= col_s2_ff;
      if (col_s2_ff == col_s3_ff)
        col_stable_ff <= col_s3_ff;
    end
  end

  // ----------------------------------------------------------------
  // card transport sequencing
  // ----------------------------------------------------------------
  crc_rd_e rd_ff;
  logic [31:0] timer_ff;
  logic [6:0] col_cnt_ff;
  logic [11:0] col_word_ff;
  logic tick;
  logic col_evt;
  logic end_evt;
  logic busy;

  assign busy = (rd_ff == RD_RUN);
  assign tick = busy & (timer_ff == 32'h0000_0000);
  assign col_evt = tick & (col_cnt_ff != COLUMNS);
  assign end_evt = tick & (col_cnt_ff == COLUMNS);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rd_ff <= RD_IDLE;
      timer_ff <= 32'h0000_0000;
      col_cnt_ff <= 7'h00;
    end
    else
    begin
      unique case (rd_ff)
        RD_IDLE:
        begin
          if (f_feed)
          begin
            rd_ff <= RD_RUN;
            timer_ff <= 32'(COL_CYCLES - 1);
            col_cnt_ff <= 7'h00;
          end
        end
        RD_RUN:
        begin
          if (end_evt)
            rd_ff <= RD_IDLE;
          else if (col_evt)
          begin
            timer_ff <= 32'(COL_CYCLES - 1);
            col_cnt_ff <= col_cnt_ff + 7'h01;
          end
          else
            timer_ff <= timer_ff - 32'h0000_0001;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      col_word_ff <= 12'h000;
    else if (col_evt)
      col_word_ff <= col_stable_ff;
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic data_ff;
  logic eop_ff;
  logic lost_ff;
  logic [2:0] sel_ff;
  logic eop_pend_ff;
  logic alarm_pend_ff;
  logic [2:0] pend;
  logic [2:0] mask_ff;
  logic [15:0] sts1;
  logic [15:0] sts2;

  assign data_in_ok = exec & (op == OP_DATA) & (station == ST_READER) & busy & data_ff;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      data_ff <= 1'b1;
    else if (col_evt)
      data_ff <= 1'b1;
    else if (f_feed & ~busy)
      data_ff <= 1'b0;
    else if (data_in_ok)
      data_ff <= 1'b0;
    else if (f_clr_ctl)
      data_ff <= ~(eop_ff | busy);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      eop_ff <= 1'b0;
    else if (end_evt)
      eop_ff <= 1'b1;
    else if (f_feed & ~busy)
      eop_ff <= 1'b0;
  end

  // lost data doubles as the alarm condition
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      lost_ff <= 1'b0;
    else if (col_evt & data_ff)
      lost_ff <= 1'b1;
    else if (f_clr_ctl | (f_feed & ~busy))
      lost_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sel_ff <= 3'h0;
    else if (f_clr_ctl | f_clr_int)
      sel_ff <= sel_req;
    else
      sel_ff <= sel_ff | sel_req;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      eop_pend_ff <= 1'b0;
    else if (end_evt & sel_ff[IX_EOP])
      eop_pend_ff <= 1'b1;
    else if (f_clr_ctl | f_clr_int)
      eop_pend_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      alarm_pend_ff <= 1'b0;
    else if (col_evt & data_ff & sel_ff[IX_ALARM])
      alarm_pend_ff <= 1'b1;
    else if (f_clr_ctl | f_clr_int)
      alarm_pend_ff <= 1'b0;
  end

  // data interrupt follows the data flag, set by each column and also by reset and by clear control while idle with no end of operation flagged
  assign pend[IX_DATA] = sel_ff[IX_DATA] & data_ff;
  assign pend[IX_EOP] = eop_pend_ff;
  assign pend[IX_ALARM] = alarm_pend_ff;

  always_comb
  begin
    sts1 = 16'h0000;
    sts1[S1_READY] = 1'b1;
    sts1[S1_BUSY] = busy;
    sts1[S1_INT] = |pend;
    sts1[S1_DATA] = data_ff;
    sts1[S1_EOP] = eop_ff;
    sts1[S1_ALARM] = lost_ff;
    sts1[S1_LOST] = lost_ff;
    sts2 = 16'h0000;
    sts2[S2_LOST] = lost_ff;
  end

  // ----------------------------------------------------------------
  // interrupt lines
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mask_ff <= MASK_RST;
    else if (wr_go & (awaddr_ff == REG_MASK) & wstrb_ff[0])
      mask_ff <= wdata_ff[2:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq_data <= 1'b0;
      irq_eop <= 1'b0;
      irq_alarm <= 1'b0;
    end
    else
    begin
      irq_data <= pend[IX_DATA] & mask_ff[IX_DATA];
      irq_eop <= pend[IX_EOP] & mask_ff[IX_EOP];
      irq_alarm <= pend[IX_ALARM] & mask_ff[IX_ALARM];
    end
  end

  // ----------------------------------------------------------------
  // transfer answer
  // ----------------------------------------------------------------
  crc_ans_e ans_ff;
  logic [15:0] ans_word_ff;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ans_ff <= ANS_NONE;
      ans_word_ff <= 16'h0000;
    end
    else if (exec)
    begin
      ans_word_ff <= 16'h0000;
      unique case (op)
        OP_FUNC:
          ans_ff <= fn_station ? ANS_REPLY : ANS_INT_REJ;
        OP_DATA:
        begin
          if (station != ST_READER)
            ans_ff <= ANS_INT_REJ;
          else if (data_in_ok)
          begin
            ans_ff <= ANS_REPLY;
            ans_word_ff <= {4'h0, col_word_ff};
          end
          else
            ans_ff <= ANS_EXT_REJ;
        end
        OP_STS1:
        begin
          ans_ff <= ANS_REPLY;
          ans_word_ff <= sts1;
        end
        OP_STS2:
        begin
          ans_ff <= ANS_REPLY;
          ans_word_ff <= sts2;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] raddr;

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign raddr = {s_axi_araddr[7:2], 2'b00};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= AXI_OKAY;
    end
    else if (s_axi_arvalid & ~rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= AXI_OKAY;
      rdata_ff <= 32'h0000_0000;
      if (raddr == REG_CMD)
        rdata_ff <= {12'h000, wdata_ff[19:0]};
      else if (raddr == REG_ANSWER)
        rdata_ff <= {ans_word_ff, 14'h0000, ans_ff};
      else if (raddr == REG_MASK)
        rdata_ff <= {29'h0000_0000, mask_ff};
      else if (raddr == REG_STATUS)
        rdata_ff <= {16'h0000, sts1};
      else
        rresp_ff <= AXI_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end
endmodule : crc_ctrl
`default_nettype wire

// ===== hdl/crc_pkg.sv
// constants for the card reader controller
package crc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ANSWER = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  // command word fields
  localparam int CMD_FUNC_LSB = 0;
  localparam int CMD_STATION_LSB = 16;
  localparam int CMD_OP_LSB = 18;
  // host transfer kinds
  typedef enum logic [1:0] {
    OP_FUNC = 2'b00,
    OP_DATA = 2'b01,
    OP_STS1 = 2'b10,
    OP_STS2 = 2'b11
  } crc_op_e;
  // answers of a transfer
  typedef enum logic [1:0] {
    ANS_NONE = 2'b00,
    ANS_REPLY = 2'b01,
    ANS_INT_REJ = 2'b10,
    ANS_EXT_REJ = 2'b11
  } crc_ans_e;
  // stations
  localparam logic [1:0] ST_NONFUNC = 2'h0;
  localparam logic [1:0] ST_READER = 2'h1;
  localparam logic [1:0] ST_AUX = 2'h2;
  localparam logic [1:0] ST_SPARE = 2'h3;
  // function word bits
  localparam int FB_CLR_CTL = 0;
  localparam int FB_CLR_INT = 1;
  localparam int FB_DATA_INT = 2;
  localparam int FB_EOP_INT = 3;
  localparam int FB_ALARM_INT = 4;
  localparam int FB_FEED = 5;
  localparam int FB_OFFSET = 6;
  // level 1 status bits
  localparam int S1_READY = 0;
  localparam int S1_BUSY = 1;
  localparam int S1_INT = 2;
  localparam int S1_DATA = 3;
  localparam int S1_EOP = 4;
  localparam int S1_ALARM = 5;
  localparam int S1_LOST = 6;
  // level 2 status bits
  localparam int S2_LOST = 0;
  // interrupt index in select, pending and mask vectors
  localparam int IX_DATA = 0;
  localparam int IX_EOP = 1;
  localparam int IX_ALARM = 2;
  // card geometry and timing
  localparam logic [6:0] COLUMNS = 7'h50;
  localparam int CLK_PERIOD_NS = 40;
  localparam int COL_PERIOD_US = 1200;
  localparam int COL_CYC = COL_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int FIRST_COL_LIMIT_MS = 40;
  localparam int FIRST_COL_LIMIT_CYC = FIRST_COL_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
  // reset values and axi response codes
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : crc_pkg

// ===== tb/crc_card_src.sv
// card reader model: single hole shifted one row per column
`timescale 1ns/10ps
`default_nettype none
module crc_card_src
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic step,
  output logic [11:0] card_column
);
  // next column pattern once the host has read one
  always @(posedge sys_clk)
  begin
    if (reset)
      card_column <= 12'h001;
    else if (step)
      card_column <= {card_column[10:0], card_column[11]};
  end
endmodule : crc_card_src
`default_nettype wire

// ===== tb/crc_ctrl_sva.sv
// port checker for the card reader controller
`timescale 1ns/10ps
`default_nettype none
module crc_ctrl_sva
  import crc_pkg::*;
#(
  parameter int COL_CYCLES = crc_pkg::COL_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] card_column,
  input wire logic irq_data,
  input wire logic irq_eop,
  input wire logic irq_alarm
);
  // ----
  // address and mask shadows
  // ----
  logic [7:0] aw_ff;
  logic [7:0] ar_ff;
  logic [2:0] w_ff;
  logic [2:0] msk_ff;
  logic ar_sts;
  logic ar_bad;
  logic aw_bad;
  assign ar_sts = s_axi_rvalid && ar_ff == REG_STATUS;
  assign ar_bad = ar_ff > REG_STATUS || ar_ff[1:0] != 2'h0;
  assign aw_bad = aw_ff > REG_STATUS || aw_ff[1:0] != 2'h0;
  always_ff @(posedge sys_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_ff <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      w_ff <= s_axi_wdata[2:0];
    if (s_axi_arvalid && s_axi_arready)
      ar_ff <= s_axi_araddr;
  end
  // mask takes effect as the response rises
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      msk_ff <= MASK_RST;
    else if ($rose(s_axi_bvalid) && aw_ff == REG_MASK)
      msk_ff <= w_ff;
  end
  // ----
  // assertions
  // ----
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  r_late_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_late_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  r_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == (ar_bad ? AXI_SLVERR : AXI_OKAY))
    else $error("wrong read response");
  b_resp_a: assert property (s_axi_bvalid && aw_bad |-> s_axi_bresp == AXI_SLVERR)
    else $error("unmapped write not refused");
  irq_gate_a: assert property (({irq_alarm, irq_eop, irq_data} & ~msk_ff) == 3'h0)
    else $error("interrupt line without mask");
  sts_ready_a: assert property (ar_sts |-> s_axi_rdata[S1_READY])
    else $error("ready status missing");
  eop_busy_a: assert property (ar_sts |-> !(s_axi_rdata[S1_EOP] && s_axi_rdata[S1_BUSY]))
    else $error("end of operation while busy");
  lost_alarm_a: assert property (ar_sts |-> s_axi_rdata[S1_LOST] == s_axi_rdata[S1_ALARM])
    else $error("lost data without alarm");
endmodule : crc_ctrl_sva
bind crc_ctrl crc_ctrl_sva #(.COL_CYCLES(COL_CYCLES)) i_sva (.*);
`default_nettype wire

// ===== tb/test_crc_ctrl.sv
// self-checking bench for the card reader controller
`timescale 1ns/10ps
`default_nettype none
module test_crc_ctrl;
  import crc_pkg::*;
  localparam int COL = 50;
  logic sys_clk, reset, step;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] card_column;
  logic irq_data, irq_eop, irq_alarm;
  logic [2:0] irqs;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  assign irqs = {irq_alarm, irq_eop, irq_data};
  crc_ctrl #(.COL_CYCLES(COL)) i_dut (.*);
  crc_card_src i_card (.*);
  // ----
  // clock, timeout and shared tasks
  // ----
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1)
        s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic cmd(input logic [1:0] op, input logic [1:0] st, input logic [15:0] fw,
                     input logic [1:0] code, input logic [15:0] word);
    wr(REG_CMD, {12'h000, op, st, fw});
    rd(REG_ANSWER);
    chk({30'h0, rv[1:0]}, {30'h0, code}, "answer code");
    if (code == ANS_REPLY && op != OP_FUNC)
      chk({16'h0, rv[31:16]}, {16'h0, word}, "input word");
  endtask : cmd
  task automatic sts(input logic [31:0] exp);
    rd(REG_STATUS);
    chk(rv, exp, "status");
  endtask : sts
  task automatic wait_irq(input int ix, input int lim);
    int n;
    n = 0;
    while (n < lim && irqs[ix] !== 1'b1)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, irqs[ix]}, 32'h1, "interrupt arrival");
  endtask : wait_irq
  // ----
  // scenarios
  // ----
  task automatic t_static;
    logic [15:0] fw [6];
    logic [31:0] ex [6];
    fw = '{16'h0004, 16'h0008, 16'h0010, 16'h0040, 16'hFF80, 16'hFFDF};
    ex = '{32'hD, 32'h9, 32'h9, 32'h9, 32'h9, 32'hD};
    cmd(OP_STS1, ST_READER, 16'h0, ANS_REPLY, 16'h0009);
    cmd(OP_STS2, ST_READER, 16'h0, ANS_REPLY, 16'h0000);
    cmd(OP_FUNC, ST_NONFUNC, 16'hFFFF, ANS_INT_REJ, 16'h0);
    cmd(OP_FUNC, ST_SPARE, 16'hFFFF, ANS_INT_REJ, 16'h0);
    cmd(OP_FUNC, ST_READER, 16'h0001, ANS_REPLY, 16'h0);
    sts(32'h9);
    cmd(OP_DATA, ST_READER, 16'h0, ANS_EXT_REJ, 16'h0);
    cmd(OP_FUNC, ST_READER, 16'h0004, ANS_REPLY, 16'h0);
    chk({29'h0, irqs}, 32'h0, "masked lines");
    wr(REG_MASK, 32'h7);
    chk({30'h0, rr}, {30'h0, AXI_OKAY}, "mask write response");
    rd(REG_MASK);
    chk({29'h0, rv[2:0]}, 32'h7, "mask readback");
    for (int i = 0; i < 6; i++)
    begin
      cmd(OP_FUNC, ST_READER, fw[i], ANS_REPLY, 16'h0);
      sts(ex[i]);
      chk({29'h0, irqs}, {31'h0, ex[i][2]}, "interrupt lines");
      cmd(OP_FUNC, ST_AUX, 16'h0002, ANS_REPLY, 16'h0);
      sts(32'h9);
    end
    rd(8'h10);
    chk({30'h0, rr}, {30'h0, AXI_SLVERR}, "unmapped response");
    chk(rv, 32'h0, "unmapped data");
    wr(8'h14, 32'hFFFF_FFFF);
    chk({30'h0, rr}, {30'h0, AXI_SLVERR}, "unmapped write response");
    rd(REG_MASK);
    chk({29'h0, rv[2:0]}, 32'h7, "mask kept");
    $display("static tests done");
  endtask : t_static
  task automatic t_card;
    int n;
    int last;
    int e0;
    n = 0;
    e0 = n_errors;
    cmd(OP_FUNC, ST_READER, 16'h003E, ANS_REPLY, 16'h0);
    sts(32'h3);
    cmd(OP_DATA, ST_READER, 16'h0, ANS_EXT_REJ, 16'h0);
    while (rv[1:0] !== ANS_REPLY && n < COL)
    begin
      wr(REG_CMD, {12'h000, OP_DATA, ST_READER, 16'h0});
      rd(REG_ANSWER);
      n++;
    end
    for (int k = 0; k < 80; k++)
    begin
      if (k > 0)
      begin
        wait_irq(IX_DATA, 2 * COL);
        if (k > 1)
          chk(32'(cyc - last), COL, "column spacing");
        last = cyc;
        sts(32'hF);
        cmd(OP_DATA, ST_READER, 16'h0, ANS_REPLY, 16'(12'h001 << (k % 12)));
      end
      else
        chk(rv, 32'h0001_0001, "first column");
      sts(32'h3);
      step <= 1'b1;
      @(posedge sys_clk);
      step <= 1'b0;
    end
    if (n_errors != e0)
      cmd(OP_FUNC, ST_READER, 16'h0040, ANS_REPLY, 16'h0);
    wait_irq(IX_EOP, 2 * COL);
    chk(32'(cyc - last), COL, "end spacing");
    chk({29'h0, irqs}, 32'h2, "end lines");
    sts(32'h15);
    cmd(OP_FUNC, ST_READER, 16'h0002, ANS_REPLY, 16'h0);
    sts(32'h11);
    cmd(OP_FUNC, ST_READER, 16'h0001, ANS_REPLY, 16'h0);
    sts(32'h11);
    $display("card tests done");
  endtask : t_card
  task automatic t_lost;
    cmd(OP_FUNC, ST_READER, 16'h003A, ANS_REPLY, 16'h0);
    wait_irq(IX_ALARM, 3 * COL);
    sts(32'h6F);
    wait_irq(IX_EOP, 82 * COL);
    sts(32'h7D);
    cmd(OP_FUNC, ST_READER, 16'h0002, ANS_REPLY, 16'h0);
    sts(32'h79);
    cmd(OP_FUNC, ST_READER, 16'h0001, ANS_REPLY, 16'h0);
    sts(32'h11);
    $display("lost data tests done");
  endtask : t_lost
  initial
  begin
    reset = 1'b1;
    step = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_static();
    t_card();
    t_lost();
    test_done();
  end
endmodule : test_crc_ctrl
`default_nettype wire
